// ### src/spipc_defines.vh
// Behaviour
// - In slave mode a byte that completes while the shift buffer still holds an unread byte sets the receive overflow flag.
// - On a receive overflow the newly shifted byte is dropped and the unread byte in the shift buffer is kept.
// - The receive overflow flag is never raised in master mode.
// - The receive overflow flag stays set until software clears it and hardware never clears it.
// - With the port enable bit at 1 the clock, data-out and data-in pins belong to the port, and the slave-select pin too in mode 0100; at 0 they are plain I/O.
// - The clock idle polarity bit gives an idle-high clock at 1 and an idle-low clock at 0.
// - Mode 0101 is a slave clocked from the clock pin that ignores the slave-select pin and leaves it free.
// - Mode 0100 is a slave clocked from the clock pin whose transfers are gated by the slave-select pin.
// - Modes 0000, 0001 and 0010 are master with the bit clock at the system clock divided by 4, 16 or 64.
// - Mode 0011 is master with the bit clock at half the timer two output rate.
// - A shift buffer write while a byte is shifting is ignored and sets the write collision flag until software clears it.
// - After eight bits the byte moves into the shift buffer and the buffer full and port interrupt flags are set.
// - A software read of the shift buffer clears the buffer full flag.
// - In master mode a shift buffer write starts a full-duplex byte transfer, most significant bit first, at the chosen rate.
`ifndef SPIPC_DEFINES_VH
`define SPIPC_DEFINES_VH

// Register byte offsets
`define SPIPC_OFF_CTRL 5'h00
`define SPIPC_OFF_BUF 5'h04
`define SPIPC_OFF_STAT 5'h08
`define SPIPC_OFF_ISTAT 5'h0C
`define SPIPC_OFF_ICLR 5'h10
`define SPIPC_OFF_IEN 5'h14

// Control register fields
`define SPIPC_CTRL_WRITE_COLLISION_FLAG 7
`define SPIPC_CTRL_OVF 6
`define SPIPC_CTRL_EN 5
`define SPIPC_CTRL_CKP 4
`define SPIPC_CTRL_MODE_MSB 3
`define SPIPC_CTRL_RST 8'h00

// Status register fields
`define SPIPC_STAT_BF 0
`define SPIPC_STAT_BUSY 1

// Interrupt status fields
`define SPIPC_IRQ_BYTE 0
`define SPIPC_IRQ_WRITE_COLLISION_FLAG 1
`define SPIPC_IRQ_OVF 2
`define SPIPC_IRQ_W 3

// Mode field codes
`define SPIPC_MODE_DIV4 4'h0
`define SPIPC_MODE_DIV16 4'h1
`define SPIPC_MODE_DIV64 4'h2
`define SPIPC_MODE_TIMER_TWO 4'h3
`define SPIPC_MODE_SLV_SS 4'h4
`define SPIPC_MODE_SLV 4'h5

// Half bit periods in system clocks
`define SPIPC_HALF_DIV4 6'h02
`define SPIPC_HALF_DIV16 6'h08
`define SPIPC_HALF_DIV64 6'h20

`define SPIPC_LAST_BIT 3'h7

`endif

// ### src/spipc_clkgen.v
`timescale 1ns/1ps
`default_nettype none
`include "spipc_defines.vh"
module spipc_clkgen (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Control
  input wire run_i,
  input wire [3:0] mode_i,
  input wire timer_two_tick_i,
  // Half bit period strobe
  output wire half_tick_o
);
  reg [5:0] cnt_ff;
  reg [5:0] nxt_cnt;
  reg tick_ff;
  reg nxt_tick;
  reg [5:0] half_lim;

  always @* begin
    case (mode_i)
      `SPIPC_MODE_DIV16: half_lim = `SPIPC_HALF_DIV16;
      `SPIPC_MODE_DIV64: half_lim = `SPIPC_HALF_DIV64;
      default: half_lim = `SPIPC_HALF_DIV4;
    endcase
  end

  always @* begin
    nxt_cnt = 6'h00;
    nxt_tick = 1'b0;
    if (run_i) begin
      if (mode_i == `SPIPC_MODE_TIMER_TWO) begin
        // One timer tick per half period gives half the timer rate
        nxt_tick = timer_two_tick_i;
      end else if (cnt_ff == half_lim - 6'h01) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 6'h01;
      end
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= 6'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign half_tick_o = tick_ff & run_i;
endmodule
`default_nettype wire

// ### src/spipc_edge.v
`timescale 1ns/1ps
`default_nettype none
module spipc_edge #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Pin levels
  input wire [WIDTH-1:0] pin_i,
  // Registered level and its previous value
  output wire [WIDTH-1:0] q_o,
  output wire [WIDTH-1:0] prev_o
);
  reg [WIDTH-1:0] q_ff;
  reg [WIDTH-1:0] prev_ff;

  // Pins are synchronous; one stage plus history for edges
  always @(posedge clk_i) begin
    if (srst_i) begin
      q_ff <= {WIDTH{1'b0}};
      prev_ff <= {WIDTH{1'b0}};
    end else begin
      q_ff <= pin_i;
      prev_ff <= q_ff;
    end
  end

  assign q_o = q_ff;
  assign prev_o = prev_ff;
endmodule
`default_nettype wire

// ### src/spipc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "spipc_defines.vh"
module spipc_top (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Avalon-MM slave
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Interrupt
  output wire irq_o,
  // Timer two output strobe
  input wire timer_two_tick_i,
  // Serial clock pin
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe_o,
  // Data pins
  input wire sdi_i,
  output wire sdo_o,
  output wire sdo_oe_o,
  // Slave select pin
  input wire ss_n_i,
  // Pin ownership
  output wire port_pins_owned_o,
  output wire ss_pin_used_o
);
  // Register state
  reg [7:0] ctrl_ff;
  reg [7:0] nxt_ctrl;
  reg [7:0] rx_buf_ff;
  reg [7:0] nxt_rx_buf;
  reg bf_ff;
  reg nxt_bf;
  reg [`SPIPC_IRQ_W-1:0] istat_ff;
  reg [`SPIPC_IRQ_W-1:0] nxt_istat;
  reg [`SPIPC_IRQ_W-1:0] ien_ff;
  reg [`SPIPC_IRQ_W-1:0] nxt_ien;
  reg ack_ff;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;

  // Shift engine state
  reg [7:0] sr_ff;
  reg [7:0] nxt_sr;
  reg [2:0] cnt_ff;
  reg [2:0] nxt_cnt;
  reg busy_ff;
  reg nxt_busy;
  reg phase_ff;
  reg nxt_phase;
  reg sample_ff;
  reg nxt_sample;
  reg sdo_ff;
  reg nxt_sdo;

  wire [3:0] mode;
  wire port_en;
  wire clock_idle_polarity;
  wire is_master;
  wire is_slave;
  wire [1:0] pin_q;
  wire [1:0] pin_prev;
  wire half_tick;
  wire acc;
  wire wr_take;
  wire rd_take;
  wire wr_lane;
  wire buf_wr;
  wire buf_rd;
  wire slv_sel;
  wire slv_lead;
  wire slv_trail;
  wire m_lead;
  wire m_trail;
  wire lead;
  wire trail;
  wire done;
  wire [7:0] shifted;
  wire overflow;
  wire collide;

  assign mode = ctrl_ff[`SPIPC_CTRL_MODE_MSB:0];
  assign port_en = ctrl_ff[`SPIPC_CTRL_EN];
  assign clock_idle_polarity = ctrl_ff[`SPIPC_CTRL_CKP];

  function is_master_mode;
    input [3:0] m;
    begin
      is_master_mode = (m == `SPIPC_MODE_DIV4) | (m == `SPIPC_MODE_DIV16) |
        (m == `SPIPC_MODE_DIV64) | (m == `SPIPC_MODE_TIMER_TWO);
    end
  endfunction

  function is_slave_mode;
    input [3:0] m;
    begin
      is_slave_mode = (m == `SPIPC_MODE_SLV_SS) | (m == `SPIPC_MODE_SLV);
    end
  endfunction

  // Reserved codes leave the engine idle
  assign is_master = port_en & is_master_mode(mode);
  assign is_slave = port_en & is_slave_mode(mode);

  spipc_edge #(
    .WIDTH(2)
  ) u_edge (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i({ss_n_i, sck_i}),
    .q_o(pin_q),
    .prev_o(pin_prev)
  );

  spipc_clkgen u_clkgen (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(is_master & busy_ff),
    .mode_i(mode),
    .timer_two_tick_i(timer_two_tick_i),
    .half_tick_o(half_tick)
  );

  // Bus handshake: one wait cycle, answer on the second edge
  assign acc = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = acc & ~ack_ff;
  assign wr_take = avs_write_i & ack_ff;
  assign rd_take = avs_read_i & ack_ff;
  assign wr_lane = wr_take & avs_byteenable_i[0];
  assign buf_wr = wr_lane & (avs_address_i == `SPIPC_OFF_BUF);
  assign buf_rd = rd_take & (avs_address_i == `SPIPC_OFF_BUF);

  // Slave select gates only mode 0100; mode 0101 ignores the pin
  assign slv_sel = is_slave & ((mode == `SPIPC_MODE_SLV) | ~pin_q[1]);
  assign slv_lead = slv_sel & ((pin_q[0] ^ clock_idle_polarity) & ~(pin_prev[0] ^ clock_idle_polarity));
  assign slv_trail = slv_sel & (~(pin_q[0] ^ clock_idle_polarity) & (pin_prev[0] ^ clock_idle_polarity));
  assign m_lead = is_master & busy_ff & half_tick & ~phase_ff;
  assign m_trail = is_master & busy_ff & half_tick & phase_ff;
  assign lead = m_lead | slv_lead;
  assign trail = m_trail | (slv_trail & busy_ff);
  assign shifted = {sr_ff[6:0], sample_ff};
  assign done = trail & (cnt_ff == `SPIPC_LAST_BIT);
  // Master never overflows: each byte follows a software write
  assign overflow = done & is_slave & bf_ff;
  assign collide = buf_wr & busy_ff;

  // Shift engine
  always @* begin
    nxt_sr = sr_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_phase = phase_ff;
    nxt_sample = sample_ff;
    nxt_sdo = sdo_ff;
    if (!port_en) begin
      nxt_cnt = 3'h0;
      nxt_busy = 1'b0;
      nxt_phase = 1'b0;
    end else if (is_slave & (mode == `SPIPC_MODE_SLV_SS) & pin_q[1]) begin
      // Deselect aborts a partial byte
      nxt_cnt = 3'h0;
      nxt_busy = 1'b0;
      if (buf_wr) begin
        nxt_sr = avs_writedata_i[7:0];
        nxt_sdo = avs_writedata_i[7];
      end
    end else begin
      if (buf_wr & ~busy_ff) begin
        nxt_sr = avs_writedata_i[7:0];
        nxt_sdo = avs_writedata_i[7];
        nxt_cnt = 3'h0;
        nxt_phase = 1'b0;
        nxt_busy = is_master;
      end
      if (half_tick & is_master & busy_ff) begin
        nxt_phase = ~phase_ff;
      end
      if (lead) begin
        nxt_sample = sdi_i;
        nxt_busy = 1'b1;
      end
      if (trail) begin
        nxt_sr = shifted;
        nxt_sdo = sr_ff[6];
        nxt_cnt = cnt_ff + 3'h1;
        if (done) begin
          nxt_busy = 1'b0;
        end
      end
    end
  end

  // Registers and flags
  always @* begin
    nxt_ctrl = ctrl_ff;
    nxt_rx_buf = rx_buf_ff;
    nxt_bf = bf_ff;
    nxt_istat = istat_ff;
    nxt_ien = ien_ff;
    if (wr_lane & (avs_address_i == `SPIPC_OFF_CTRL)) begin
      nxt_ctrl[`SPIPC_CTRL_EN:0] = avs_writedata_i[`SPIPC_CTRL_EN:0];
      // Flags clear by writing zero, never set by software
      nxt_ctrl[`SPIPC_CTRL_WRITE_COLLISION_FLAG] = ctrl_ff[`SPIPC_CTRL_WRITE_COLLISION_FLAG] &
        avs_writedata_i[`SPIPC_CTRL_WRITE_COLLISION_FLAG];
      nxt_ctrl[`SPIPC_CTRL_OVF] = ctrl_ff[`SPIPC_CTRL_OVF] &
        avs_writedata_i[`SPIPC_CTRL_OVF];
    end
    if (wr_lane & (avs_address_i == `SPIPC_OFF_IEN)) begin
      nxt_ien = avs_writedata_i[`SPIPC_IRQ_W-1:0];
    end
    if (wr_lane & (avs_address_i == `SPIPC_OFF_ICLR)) begin
      nxt_istat = istat_ff & ~avs_writedata_i[`SPIPC_IRQ_W-1:0];
    end
    if (buf_rd) begin
      nxt_bf = 1'b0;
    end
    // Hardware sets win over software clears
    if (collide) begin
      nxt_ctrl[`SPIPC_CTRL_WRITE_COLLISION_FLAG] = 1'b1;
      nxt_istat[`SPIPC_IRQ_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (overflow) begin
      nxt_ctrl[`SPIPC_CTRL_OVF] = 1'b1;
      nxt_istat[`SPIPC_IRQ_OVF] = 1'b1;
    end else if (done) begin
      nxt_rx_buf = shifted;
      nxt_bf = 1'b1;
    end
    if (done) begin
      nxt_istat[`SPIPC_IRQ_BYTE] = 1'b1;
    end
  end

  // Read data is latched in the wait cycle and stands at the answer edge
  always @* begin
    nxt_rdata = 32'h00000000;
    case (avs_address_i)
      `SPIPC_OFF_CTRL: nxt_rdata[7:0] = ctrl_ff;
      `SPIPC_OFF_BUF: nxt_rdata[7:0] = rx_buf_ff;
      `SPIPC_OFF_STAT: begin
        nxt_rdata[`SPIPC_STAT_BF] = bf_ff;
        nxt_rdata[`SPIPC_STAT_BUSY] = busy_ff;
      end
      `SPIPC_OFF_ISTAT: nxt_rdata[`SPIPC_IRQ_W-1:0] = istat_ff;
      `SPIPC_OFF_IEN: nxt_rdata[`SPIPC_IRQ_W-1:0] = ien_ff;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_ff <= `SPIPC_CTRL_RST;
      rx_buf_ff <= 8'h00;
      bf_ff <= 1'b0;
      istat_ff <= {`SPIPC_IRQ_W{1'b0}};
      ien_ff <= {`SPIPC_IRQ_W{1'b0}};
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      sr_ff <= 8'h00;
      cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      phase_ff <= 1'b0;
      sample_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rx_buf_ff <= nxt_rx_buf;
      bf_ff <= nxt_bf;
      istat_ff <= nxt_istat;
      ien_ff <= nxt_ien;
      ack_ff <= acc & ~ack_ff;
      if (acc & ~ack_ff) begin
        rdata_ff <= nxt_rdata;
      end
      sr_ff <= nxt_sr;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      phase_ff <= nxt_phase;
      sample_ff <= nxt_sample;
      sdo_ff <= nxt_sdo;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign irq_o = |(istat_ff & ien_ff);

  // Pins go to the port only while enabled
  assign port_pins_owned_o = port_en;
  assign ss_pin_used_o = port_en & (mode == `SPIPC_MODE_SLV_SS);
  assign sck_o = clock_idle_polarity ^ phase_ff;
  assign sck_oe_o = is_master;
  assign sdo_o = sdo_ff;
  // Deselected slave floats its data line
  assign sdo_oe_o = is_master | slv_sel;
endmodule
`default_nettype wire

// ### testbench/spipc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spipc_mon (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register bus
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pins
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic sdo_oe_o,
  input wire logic ss_n_i,
  input wire logic port_pins_owned_o,
  input wire logic ss_pin_used_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  logic [7:0] ctl_ff;
  logic [6:0] gap_ff;
  logic sck_q_ff;
  wire en = ctl_ff[5];
  wire [3:0] md = ctl_ff[3:0];
  wire mst = en && (md < 4'h3);
  wire edg = sck_o != sck_q_ff;
  wire [6:0] half = (md == 4'h0) ? 7'h02 : (md == 4'h1) ? 7'h08 : 7'h20;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl_ff <= 8'h00;
      gap_ff <= 7'h00;
      sck_q_ff <= 1'h0;
    end else begin
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h00)
        ctl_ff <= avs_writedata_i[7:0];
      sck_q_ff <= sck_o;
      // Saturates so long idle spans never wrap
      gap_ff <= edg ? 7'h01 : gap_ff + {6'h00, gap_ff != 7'h7F};
    end
  end
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("long wait");
  AST_CTRL_READ: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 5'h00
    |-> avs_readdata_o[5:0] == ctl_ff[5:0] && avs_readdata_o[31:8] == 24'h0) else $error("ctrl");
  AST_OWNED: assert property (port_pins_owned_o == en) else $error("owned");
  AST_SS_USED: assert property (ss_pin_used_o == (en && md == 4'h4)) else $error("ss use");
  AST_OFF: assert property ((!en) [*2] |-> !sck_oe_o && !sdo_oe_o) else $error("off");
  AST_SLV_FREE: assert property ((en && md == 4'h5) [*2] |-> sdo_oe_o && !sck_oe_o)
    else $error("slave oe");
  AST_SS_GATE: assert property ((en && md == 4'h4 && ss_n_i) [*3] |-> !sdo_oe_o)
    else $error("ss gate");
  AST_MST_CLK: assert property ((en && md < 4'h4) [*2] |-> sck_oe_o) else $error("mst");
  // Polarity write flips the clock pin in the same cycle and the gap count follows a cycle later, hence the two-deep guard
  AST_IDLE_LVL: assert property (mst && sck_oe_o && gap_ff > 7'h40 && ctl_ff == $past(ctl_ff, 2)
    |-> sck_o == ctl_ff[4]) else $error("idle level");
  AST_HALF_BIT: assert property (mst && sck_oe_o && edg && sck_o == ctl_ff[4]
    && ctl_ff == $past(ctl_ff, 2) |-> gap_ff == half) else $error("rate");
  CVR_TMR: cover property (en && md == 4'h3 && edg);
  CVR_SEL: cover property ((en && md == 4'h4 && !ss_n_i) [*3]);
  CVR_OVF: cover property (avs_read_i && !avs_waitrequest_o && avs_readdata_o[6]);
endmodule
bind spipc_top spipc_mon u_mon (.clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .sck_o, .sck_oe_o, .sdo_oe_o,
  .ss_n_i, .port_pins_owned_o, .ss_pin_used_o);
`default_nettype wire

// ### testbench/spipc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module spipc_peer (
  // Clock and polarity
  input wire logic clk_i,
  input wire logic ckp_i,
  // From the device
  input wire logic dev_sck_i,
  input wire logic dev_sck_oe_i,
  input wire logic dev_sdo_i,
  // To the device
  output logic sck_o,
  output logic sdi_o,
  output logic ss_n_o
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic lead_q = 1'h0;
  logic act = 1'h0;
  initial begin
    sck_o = 1'h0;
    sdi_o = 1'h0;
    ss_n_o = 1'h1;
  end
  // Slave role: sample on leading edge, next bit after trailing
  always @(posedge clk_i) begin
    lead_q <= dev_sck_i ^ ckp_i;
    if (!act)
      sck_o <= ckp_i;
    if (!act && !dev_sck_oe_i)
      sdi_o <= !sdi_o; // Released line keeps moving so no stale bit is read
    else if (dev_sck_oe_i && (dev_sck_i ^ ckp_i) && !lead_q)
      rx <= {rx[6:0], dev_sdo_i};
    else if (dev_sck_oe_i && !(dev_sck_i ^ ckp_i) && lead_q) begin
      tx <= {tx[6:0], 1'h0};
      sdi_o <= tx[6];
    end
  end
  task automatic load(input logic [7:0] b);
    tx = b;
    sdi_o <= b[7];
  endtask
  // Master role, four-cycle half bit
  task automatic send(input logic [7:0] b, input logic sel);
    act = 1'h1;
    @(posedge clk_i);
    ss_n_o <= !sel;
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= b[i];
      repeat (2) @(posedge clk_i);
      sck_o <= !ckp_i;
      repeat (4) @(posedge clk_i);
      rx <= {rx[6:0], dev_sdo_i};
      sck_o <= ckp_i;
      repeat (2) @(posedge clk_i);
    end
    ss_n_o <= 1'h1;
    act = 1'h0;
  endtask
endmodule
`default_nettype wire

// ### testbench/spipc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module spipc_top_bench;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic rd = 1'h0, wr = 1'h0, tick = 1'h0, clock_idle_polarity = 1'h0;
  logic [4:0] adr = 5'h00;
  logic [1:0] tc = 2'h0;
  logic [31:0] wd = 32'h0, q = 32'h0;
  wire [31:0] rdata;
  wire wait_w, irq, sck, sck_oe, sdo, sdo_oe, owned, p_sck, p_sdi, p_ss_n;
  int miscompares = 0, comparisons = 0;
  spipc_top uut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_w), .irq_o(irq), .timer_two_tick_i(tick), .sck_i(p_sck),
    .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(p_sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .ss_n_i(p_ss_n), .port_pins_owned_o(owned), .ss_pin_used_o());
  spipc_peer peer (.clk_i(clk_i), .ckp_i(clock_idle_polarity), .dev_sck_i(sck), .dev_sck_oe_i(sck_oe),
    .dev_sdo_i(sdo), .sck_o(p_sck), .sdi_o(p_sdi), .ss_n_o(p_ss_n));
  initial forever #12.5 clk_i = !clk_i;
  always @(posedge clk_i) begin
    tc <= tc + 2'h1;
    tick <= tc == 2'h3;
  end
  task automatic bus(input logic r, input logic [4:0] a, input logic [7:0] d);
    logic w;
    w = 1'h1;
    @(posedge clk_i);
    adr <= a;
    rd <= r;
    wr <= !r;
    wd <= {24'h0, d};
    while (w !== 1'h0) begin
      #1;
      w = wait_w;
      q = rdata;
      @(posedge clk_i);
    end
    rd <= 1'h0;
    wr <= 1'h0;
    #1;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string nm);
    bus(1'h1, a, 8'h00);
    `CHK(nm, {24'h0, e}, q)
  endtask
  task automatic wirq;
    int k;
    k = 0;
    while (irq !== 1'h1 && k < 4000) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    `CHK("irq", 1'h1, irq)
  endtask
  task automatic t_reset;
    rdc(5'h00, 8'h00, "ctrl");
    rdc(5'h08, 8'h00, "status");
    rdc(5'h1C, 8'h00, "unmapped");
    `CHK("owned", 1'h0, owned)
  endtask
  // Buffer left unread so a wrong master overflow would show
  task automatic t_master;
    logic [7:0] c;
    bus(1'h0, 5'h14, 8'h01);
    for (int m = 0; m < 4; m++) begin
      c = 8'h20 | {3'h0, m[0], 4'h0} | m[7:0];
      clock_idle_polarity = m[0];
      bus(1'h0, 5'h00, c);
      repeat (2) @(posedge clk_i);
      peer.load(8'h3C ^ m[7:0]);
      bus(1'h0, 5'h10, 8'h07);
      bus(1'h0, 5'h04, 8'hA5 ^ m[7:0]);
      if (m == 0)
        bus(1'h0, 5'h04, 8'h11);
      wirq();
      `CHK("peer rx", 8'hA5 ^ m[7:0], peer.rx)
      rdc(5'h00, c | (m == 0 ? 8'h80 : 8'h00), "ctrl");
      bus(1'h0, 5'h00, c);
    end
    rdc(5'h08, 8'h01, "full");
    rdc(5'h04, 8'h3F, "rx byte");
    rdc(5'h08, 8'h00, "emptied");
  endtask
  task automatic t_slave;
    clock_idle_polarity = 1'h1;
    bus(1'h0, 5'h00, 8'h35);
    bus(1'h0, 5'h10, 8'h07);
    bus(1'h0, 5'h14, 8'h04);
    bus(1'h0, 5'h04, 8'hC3);
    peer.send(8'h5A, 1'h1);
    `CHK("slave out", 8'hC3, peer.rx)
    rdc(5'h08, 8'h01, "full");
    peer.send(8'h66, 1'h1);
    rdc(5'h00, 8'h75, "overflow");
    `CHK("irq", 1'h1, irq)
    rdc(5'h04, 8'h5A, "kept");
    bus(1'h0, 5'h14, 8'h00);
    `CHK("masked", 1'h0, irq)
    bus(1'h0, 5'h10, 8'h04);
    bus(1'h0, 5'h14, 8'h04);
    `CHK("cleared", 1'h0, irq)
    rdc(5'h00, 8'h75, "sticky");
    bus(1'h0, 5'h00, 8'h35);
    rdc(5'h00, 8'h35, "sw clear");
  endtask
  task automatic t_select;
    bus(1'h0, 5'h00, 8'h34);
    peer.send(8'h99, 1'h0);
    rdc(5'h08, 8'h00, "deselected");
    peer.send(8'h99, 1'h1);
    rdc(5'h08, 8'h01, "selected");
    rdc(5'h04, 8'h99, "sel data");
    bus(1'h0, 5'h00, 8'h00);
    `CHK("freed", 1'h0, owned)
  endtask
  task final_report;
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'h0;
    t_reset();
    t_master();
    t_slave();
    t_select();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
